// ==== pkg/stc_defs.svh ====
/*
 Constants for the bus transfer control block: bit positions, widths,
 FIFO depth, interrupt source numbers and timing counts. Assumes inclusion by bare name.
*/
`ifndef STC_DEFS_SVH
`define STC_DEFS_SVH

`define STC_CNT_W        24
`define STC_PTR_W        32
`define STC_FIFO_DEPTH   8
`define STC_FIFO_AW      3
`define STC_RDY_BIT      1
`define STC_DIR_BIT      2
`define STC_CLEAR_CHANNEL_BIT   1
`define STC_RSTO_BIT     0
`define STC_RSTSEEN_BIT  5
`define STC_IRQCLR_BIT   2
`define STC_APIO_BIT     3
`define STC_NSRC         8
`define STC_SRC_SELDONE  0
`define STC_SRC_BUSRST   1
`define STC_SRC_XFRDONE  2
`define STC_SRC_BUSFREE  3
`define STC_SRC_SELTO    4
`define STC_SRC_PIORDY   5
`define STC_SRC_PHMIS    6
`define STC_SRC_SPARE    7
`define STC_HOLD_NS      20
`define STC_CLK_MHZ      250
`define STC_HOLD_CYC     ((`STC_HOLD_NS * `STC_CLK_MHZ + 999) / 1000)

`endif

// ==== pkg/stc_pkg.sv ====
/*
 Types for the bus transfer control block.
 Assumes stc_defs.svh supplies the numeric constants.
*/
package stc_pkg;
  `include "stc_defs.svh"

  // Bus-side handshake signals
  typedef struct packed {
    logic       req;
    logic       ack;
    logic       io_in;
    logic [7:0] data;
  } stc_bus_t;

  // Phases of the transfer on the bus
  typedef enum logic [1:0] {
    STC_PH_CMD,
    STC_PH_DATA,
    STC_PH_OTHER
  } stc_phase_t;

  // Handshake engine states
  typedef enum logic [2:0] {
    STC_IDLE,
    STC_REQ,
    STC_WAIT_ACK_OFF,
    STC_DONE
  } stc_hs_t;
endpackage : stc_pkg

// ==== hw/stc_fifo.sv ====
/*
 Small bus-side byte FIFO used in DMA mode.
 Assumes one clock; flush empties it in one cycle.
*/
`timescale 1ns/10ps
`include "stc_defs.svh"
module stc_fifo
  import stc_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = `STC_FIFO_DEPTH,
  parameter int AW    = `STC_FIFO_AW
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
  logic             push, pop;

  // Pointer arithmetic with extra wrap bit
  always_comb begin
    push     = in_valid && in_ready;
    pop      = out_valid && out_ready;
    in_ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
    out_valid = wp_q != rp_q;
    out_data = mem_q[rp_q[AW-1:0]];
    wp_d = flush ? '0 : wp_q + (AW+1)'(push);
    rp_d = flush ? '0 : rp_q + (AW+1)'(pop);
  end

  // Pointer registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (clk_en) begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge core_clk) begin
    if (clk_en && push) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule : stc_fifo

// ==== hw/stc_xfer.sv ====
/*
 Bus transfer control: target-mode automatic PIO handshake, DMA byte
 movement through a small FIFO, pointer and remaining-count counters,
 interrupt status/mask/clear and bus reset out / reset seen.
 Assumes bus pins are synchronous-ready after the internal two-flop
 stages and that the controller keeps enables off while loading counters.
*/
`timescale 1ns/10ps
`include "stc_defs.svh"
module stc_xfer
  import stc_pkg::*;
#(
  parameter int CNT_W = `STC_CNT_W,
  parameter int PTR_W = `STC_PTR_W,
  parameter int NSRC  = `STC_NSRC
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic             chip_reset_bit,
  input  wire logic             target_mode,
  input  wire logic             auto_pio_enable,
  input  wire logic             bus_dma_enable,
  input  wire logic             bus_engine_enable,
  input  wire logic             dir_to_host,
  input  wire logic             count_wrap_enable,
  input  wire logic             clear_channel,
  input  wire logic             bus_reset_out,
  input  wire logic             sync_rate,
  input  wire stc_phase_t       phase,
  input  wire logic             phase_mismatch_flag,
  input  wire logic             latch_rd,
  input  wire logic             latch_wr,
  input  wire logic [7:0]       latch_wdata,
  input  wire logic             host_pointer_load,
  input  wire logic [PTR_W-1:0] host_ptr_value,
  input  wire logic             count_load,
  input  wire logic [CNT_W-1:0] count_value,
  input  wire logic [NSRC-1:0]  irq_events,
  input  wire logic [NSRC-1:0]  scsi_irq_mask_a,
  input  wire logic [NSRC-1:0]  scsi_irq_clear_a,
  input  wire logic             bus_irq_line_clear,
  input  wire logic             pin_ack,
  input  wire logic             pin_rst,
  input  wire logic [7:0]       pin_data,
  input  wire logic             dfifo_in_ready,
  input  wire logic             dfifo_out_valid,
  input  wire logic [7:0]       dfifo_out_data,
  output logic                  dfifo_in_valid,
  output logic      [7:0]       dfifo_in_data,
  output logic                  dfifo_out_ready,
  output logic                  req_o,
  output logic      [7:0]       data_o,
  output logic                  data_oe,
  output logic                  rst_o,
  output logic      [7:0]       pio_data_latch,
  output logic                  pio_ready_flag,
  output logic      [NSRC-1:0]  scsi_status_reg_a,
  output logic                  bus_irq_line,
  output logic                  bus_count_done,
  output logic                  bus_reset_seen,
  output logic                  sync_active,
  output logic      [PTR_W-1:0] bus_byte_pointer,
  output logic      [CNT_W-1:0] remaining_byte_count
);
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic [2:0] ack_q;
  logic [1:0] rst_in_q;
  logic [7:0] dat_q1, dat_q2;
  logic       ack_rise, ack_s, rstin_s;

  // Reset release through two flip-flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) rst_sync_q <= 2'h0;
    else          rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Pin synchronisers plus one edge stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q    <= 3'h0;
      rst_in_q <= 2'h0;
      dat_q1   <= 8'h00;
      dat_q2   <= 8'h00;
    end else if (clk_en) begin
      ack_q    <= {ack_q[1:0], pin_ack};
      rst_in_q <= {rst_in_q[0], pin_rst};
      dat_q1   <= pin_data;
      dat_q2   <= dat_q1;
    end
  end
  assign ack_s    = ack_q[1];
  assign ack_rise = ack_q[1] && !ack_q[2];
  assign rstin_s  = rst_in_q[1];

  // Handshake state
  stc_hs_t          hs_q, hs_d;
  logic             req_q, req_d, rdy_q, rdy_d, oe_q, oe_d;
  logic [7:0]       lat_q, lat_d, dout_q, dout_d;
  logic             dma_on, apio_ok, byte_done, cnt_run, fflush;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [PTR_W-1:0] ptr_q, ptr_d;
  logic             done_q, done_d, dmaen_q;
  logic             f_in_v, f_in_r, f_out_v, f_out_r;
  logic [7:0]       f_out_d;
  logic             fin_q, fin_d;
  logic [7:0]       fdat_q, fdat_d;

  // Handshake and PIO/DMA data path
  always_comb begin
    dma_on  = bus_dma_enable && bus_engine_enable;
    apio_ok = auto_pio_enable && !phase_mismatch_flag
              && target_mode;
    cnt_run = (bus_dma_enable || auto_pio_enable || bus_engine_enable)
              && ((cnt_q != '0) || count_wrap_enable);
    hs_d   = hs_q;
    req_d  = req_q;
    rdy_d  = rdy_q;
    lat_d  = lat_q;
    dout_d = dout_q;
    oe_d   = oe_q;
    fin_d  = 1'b0;
    fdat_d = fdat_q;
    f_out_r = 1'b0;
    byte_done = 1'b0;
    if (apio_ok && !dma_on) begin
      if (!dir_to_host) begin
        // Target Out: initiator sends
        oe_d = 1'b0;
        if (latch_rd) begin
          req_d = 1'b1;
          rdy_d = 1'b0;
        end
        if (ack_rise && req_q) begin
          lat_d = dat_q2;
          rdy_d = 1'b1;
          req_d = 1'b0;
          byte_done = cnt_run;
        end
      end else begin
        // Target In: device sends
        if (latch_wr) begin
          dout_d = latch_wdata;
          oe_d   = 1'b1;
          req_d  = 1'b1;
          rdy_d  = 1'b0;
        end
        if (ack_rise && req_q) begin
          req_d = 1'b0;
          rdy_d = 1'b1;
          byte_done = cnt_run;
        end
      end
    end else if (dma_on && cnt_run && !done_q) begin
      // DMA engine; sync only in data phase
      case (hs_q)
        STC_IDLE: begin
          if (!dir_to_host && f_out_v) begin
            dout_d  = f_out_d;
            oe_d    = 1'b1;
            f_out_r = 1'b1;
            req_d   = 1'b1;
            hs_d    = STC_REQ;
          end else if (dir_to_host && f_in_r) begin
            oe_d  = 1'b0;
            req_d = 1'b1;
            hs_d  = STC_REQ;
          end
        end
        STC_REQ: begin
          if (ack_s) begin
            req_d = 1'b0;
            if (dir_to_host) begin
              fin_d  = 1'b1;
              fdat_d = dat_q2;
            end else begin
              byte_done = 1'b1;
            end
            hs_d = STC_WAIT_ACK_OFF;
          end
        end
        STC_WAIT_ACK_OFF: begin
          if (!ack_s) hs_d = STC_IDLE;
        end
        default: hs_d = STC_IDLE;
      endcase
    end else begin
      hs_d = STC_IDLE;
      if (!apio_ok) req_d = 1'b0;
    end
    // Inbound byte counts once written into the FIFO
    if (fin_q && f_in_r) byte_done = 1'b1;
  end
  assign f_in_v = fin_q;

  // Counters; pointer and count step together on each byte in either direction; PIO bytes step them only while cnt_run holds
  always_comb begin
    ptr_d  = ptr_q;
    cnt_d  = cnt_q;
    done_d = done_q;
    if (host_pointer_load) ptr_d = host_ptr_value;
    if (count_load) begin
      cnt_d  = count_value;
      done_d = (count_value == '0) && !count_wrap_enable;
    end else if (byte_done) begin
      ptr_d = ptr_q + PTR_W'(1);
      cnt_d = cnt_q - CNT_W'(1);
      if (cnt_q == CNT_W'(1) && !count_wrap_enable)
        done_d = 1'b1;
    end
  end

  // FIFO flush conditions
  assign fflush = chip_reset_bit || clear_channel
                  || (dmaen_q && !bus_dma_enable && dir_to_host
                      && cnt_q == '0 && !target_mode);

  stc_fifo #(
    .WIDTH (8),
    .DEPTH (`STC_FIFO_DEPTH),
    .AW    (`STC_FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .flush     (fflush),
    .in_valid  (dir_to_host ? f_in_v : (dfifo_out_valid && dfifo_out_ready)),
    .in_ready  (f_in_r),
    .in_data   (dir_to_host ? fdat_q : dfifo_out_data),
    .out_valid (f_out_v),
    .out_ready (dir_to_host ? dfifo_in_ready : f_out_r),
    .out_data  (f_out_d)
  );

  // Interrupt status and line
  logic [NSRC-1:0] st_q, st_d;
  logic            irq_q, irq_d, seen_q, seen_d, sync_q, sync_d;
  logic [NSRC-1:0] ev, ev_q, ev_rise;
  logic [2:0]      own_q, own_d;
  always_comb begin
    ev = irq_events;
    ev[`STC_SRC_XFRDONE] = irq_events[`STC_SRC_XFRDONE] || done_q;
    ev[`STC_SRC_BUSRST]  = seen_q;
    ev[`STC_SRC_PIORDY]  = rdy_q;
    // A rising condition sets its bit and beats a clear write
    ev_rise = ev & ~ev_q;
    st_d = ((st_q & ~scsi_irq_clear_a) | ev_rise) & ev;
    irq_d = irq_q;
    if (bus_irq_line_clear) irq_d = 1'b0;
    if (|(ev_rise & scsi_irq_mask_a))
      irq_d = 1'b1;
    // Held as a level; extra events do not re-pulse
    // Own reset still inside the pin synchroniser stays masked
    own_d  = {own_q[1:0], rst_o};
    seen_d = rstin_s && !bus_reset_out && !rst_o && (own_q == 3'h0);
    seen_d = seen_d || (seen_q && rstin_s);
    sync_d = sync_rate && (phase == STC_PH_DATA);
  end

  // State registers other than the reset and pin synchronisers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_q   <= STC_IDLE;
      req_q  <= 1'b0;
      rdy_q  <= 1'b0;
      lat_q  <= 8'h00;
      dout_q <= 8'h00;
      oe_q   <= 1'b0;
      fin_q  <= 1'b0;
      fdat_q <= 8'h00;
      cnt_q  <= '0;
      ptr_q  <= '0;
      done_q <= 1'b0;
      dmaen_q <= 1'b0;
      st_q   <= '0;
      irq_q  <= 1'b0;
      seen_q <= 1'b0;
      ev_q   <= '0;
      own_q  <= 3'h0;
      sync_q <= 1'b0;
      rst_o  <= 1'b0;
      dfifo_in_valid  <= 1'b0;
      dfifo_in_data   <= 8'h00;
      dfifo_out_ready <= 1'b0;
    end else if (clk_en) begin
      hs_q   <= hs_d;
      req_q  <= req_d;
      rdy_q  <= rdy_d;
      lat_q  <= lat_d;
      dout_q <= dout_d;
      oe_q   <= oe_d;
      fin_q  <= fin_d || (fin_q && !f_in_r);
      fdat_q <= fdat_d;
      cnt_q  <= cnt_d;
      ptr_q  <= ptr_d;
      done_q <= done_d;
      dmaen_q <= bus_dma_enable;
      st_q   <= st_d;
      irq_q  <= irq_d;
      seen_q <= seen_d;
      ev_q   <= ev;
      own_q  <= own_d;
      sync_q <= sync_d;
      rst_o  <= bus_reset_out;
      dfifo_in_valid  <= dir_to_host && f_out_v && dfifo_in_ready;
      dfifo_in_data   <= f_out_d;
      // Ready every other cycle so a nearly full FIFO is never overrun
      dfifo_out_ready <= !dir_to_host && f_in_r && dma_on
                         && !dfifo_out_ready;
    end
  end

  // Outputs straight from registers
  assign req_o                = req_q;
  assign data_o               = dout_q;
  assign data_oe              = oe_q;
  assign pio_data_latch       = lat_q;
  assign pio_ready_flag       = rdy_q;
  assign scsi_status_reg_a    = st_q;
  assign bus_irq_line         = irq_q;
  assign bus_count_done       = done_q;
  assign bus_reset_seen       = seen_q;
  assign sync_active          = sync_q;
  assign bus_byte_pointer     = ptr_q;
  assign remaining_byte_count = cnt_q;
endmodule : stc_xfer

// ==== sim/stc_xfer_checker.sv ====
/*
 Port-level assertions for the bus transfer block.
 Assumes binding to stc_xfer; one clock, reset_n active low.
*/
`timescale 1ns/10ps
module stc_xfer_checker
  import stc_pkg::*;
#(
  parameter int CNT_W = 24,
  parameter int NSRC  = 8
) (
  input wire logic             core_clk,
  input wire logic             reset_n,
  input wire logic             target_mode,
  input wire logic             auto_pio_enable,
  input wire logic             bus_dma_enable,
  input wire logic             dir_to_host,
  input wire stc_phase_t       phase,
  input wire logic             phase_mismatch_flag,
  input wire logic             latch_rd,
  input wire logic             latch_wr,
  input wire logic [7:0]       latch_wdata,
  input wire logic             count_load,
  input wire logic [NSRC-1:0]  irq_events,
  input wire logic [NSRC-1:0]  scsi_irq_mask_a,
  input wire logic             bus_irq_line_clear,
  input wire logic             bus_reset_out,
  input wire logic             req_o,
  input wire logic [7:0]       data_o,
  input wire logic             data_oe,
  input wire logic             rst_o,
  input wire logic             pio_ready_flag,
  input wire logic             bus_irq_line,
  input wire logic             sync_active,
  input wire logic [CNT_W-1:0] remaining_byte_count
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Latch accesses that the handshake engine must accept
  logic pio_ok;
  assign pio_ok = target_mode && auto_pio_enable && !phase_mismatch_flag
                  && !bus_dma_enable;

  AST_PIO_RD: assert property (latch_rd && pio_ok && !dir_to_host
    |-> ##[1:2] (req_o && !pio_ready_flag))
    else $error("no REQ after latch read");
  AST_PIO_WR: assert property (latch_wr && pio_ok && dir_to_host
    |-> ##[1:2] (req_o && data_oe && data_o == latch_wdata
    && !pio_ready_flag)) else $error("latch write not driven");
  AST_ACK_RDY: assert property ($fell(req_o) && auto_pio_enable
    |-> ##[0:1] pio_ready_flag) else $error("ready not set on ACK");
  AST_REQ_PHASE: assert property ($rose(req_o) && !bus_dma_enable
    |-> !$past(phase_mismatch_flag)) else $error("REQ on mismatch");
  AST_IRQ_HOLD: assert property (bus_irq_line && !bus_irq_line_clear
    |=> bus_irq_line) else $error("interrupt dropped uncleared");
  AST_IRQ_MASK: assert property ($rose(bus_irq_line) |->
    |($past(scsi_irq_mask_a) & ($past(irq_events) | $past(irq_events, 2))))
    else $error("interrupt without masked event");
  AST_CNT_STEP: assert property ($changed(remaining_byte_count)
    && !$past(count_load) && !$past(count_load, 2)
    |-> remaining_byte_count == $past(remaining_byte_count) - 1'b1)
    else $error("count moved by other than one");
  AST_RST_OUT: assert property ($changed(bus_reset_out)
    |-> ##[1:3] (rst_o == bus_reset_out)) else $error("bus reset mismatch");
  AST_CMD_ASYNC: assert property ((phase == STC_PH_CMD)[*3]
    |-> !sync_active) else $error("sync timing in command phase");
endmodule : stc_xfer_checker

// ==== sim/stc_init_model.sv ====
/*
 Behavioural initiator answering the target's REQ with ACK.
 Assumes the bench sets tx_byte and delay before each REQ.
*/
`timescale 1ns/10ps
module stc_init_model (
  input  wire logic       core_clk,
  input  wire logic       req_o,
  input  wire logic [7:0] data_o,
  input  wire logic       data_oe,
  input  wire logic [7:0] tx_byte,
  input  wire logic [3:0] delay,
  output logic            pin_ack,
  output logic      [7:0] pin_data,
  output logic      [7:0] rx_byte
);
  int n;
  // Data first, then ACK; ACK held until REQ falls or 64 cycles pass
  initial begin
    pin_ack = 1'b0;
    pin_data = 8'h5a;
    rx_byte = 8'h00;
    forever begin
      @(posedge core_clk);
      if (req_o === 1'b1) begin
        repeat (delay) @(posedge core_clk);
        if (data_oe !== 1'b1) pin_data <= tx_byte;
        else rx_byte <= data_o;
        @(posedge core_clk);
        pin_ack <= 1'b1;
        n = 0;
        while (req_o === 1'b1 && n < 64) begin
          @(posedge core_clk);
          n++;
        end
        pin_ack <= 1'b0;
        pin_data <= ~pin_data; // Released lines show no stale byte
      end
    end
  end
endmodule : stc_init_model

// ==== sim/tb_top.sv ====
/*
 Self-checking bench: PIO handshakes, counters, interrupts, bus reset.
 Assumes stc_pkg, the design, checker and initiator model compiled first.
*/
`timescale 1ns/10ps
bind stc_xfer stc_xfer_checker #(.CNT_W(CNT_W), .NSRC(NSRC)) u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .target_mode(target_mode),
  .auto_pio_enable(auto_pio_enable), .bus_dma_enable(bus_dma_enable),
  .dir_to_host(dir_to_host), .phase(phase), .latch_rd(latch_rd),
  .phase_mismatch_flag(phase_mismatch_flag), .latch_wr(latch_wr),
  .latch_wdata(latch_wdata), .count_load(count_load), .rst_o(rst_o),
  .irq_events(irq_events), .scsi_irq_mask_a(scsi_irq_mask_a),
  .bus_irq_line_clear(bus_irq_line_clear), .bus_reset_out(bus_reset_out),
  .req_o(req_o), .data_o(data_o), .data_oe(data_oe),
  .pio_ready_flag(pio_ready_flag), .bus_irq_line(bus_irq_line),
  .sync_active(sync_active), .remaining_byte_count(remaining_byte_count));
module tb_top
  import stc_pkg::*;
;
  logic        core_clk, reset_n, target_mode, auto_pio_enable, frst;
  logic        bus_dma_enable, bus_engine_enable, dir_to_host, sync_rate;
  logic        count_wrap_enable, clear_channel, bus_reset_out, pin_rst;
  logic        phase_mismatch_flag, latch_rd, latch_wr, count_load;
  logic        host_pointer_load, bus_irq_line_clear, pin_ack, req_o;
  logic        data_oe, rst_o, pio_ready_flag, bus_irq_line, sync_active;
  logic        bus_count_done, bus_reset_seen, dfo_v;
  logic [7:0]  latch_wdata, pin_data, data_o, pio_data_latch, tx, rx;
  logic [7:0]  irq_events, scsi_irq_mask_a, scsi_irq_clear_a;
  logic [7:0]  scsi_status_reg_a, dfo_d;
  logic [3:0]  dly;
  logic [31:0] host_ptr_value, bus_byte_pointer;
  logic [23:0] count_value, remaining_byte_count;
  stc_phase_t  phase;
  int          n_mismatch = 0;
  int          n_checks = 0;

  // Reset line is shared with a foreign initiator
  assign pin_rst = rst_o | frst;

  stc_xfer u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
    .chip_reset_bit(1'b0), .target_mode(target_mode),
    .auto_pio_enable(auto_pio_enable), .bus_dma_enable(bus_dma_enable),
    .bus_engine_enable(bus_engine_enable), .dir_to_host(dir_to_host),
    .count_wrap_enable(count_wrap_enable), .clear_channel(clear_channel),
    .bus_reset_out(bus_reset_out), .sync_rate(sync_rate), .phase(phase),
    .phase_mismatch_flag(phase_mismatch_flag), .latch_rd(latch_rd),
    .latch_wr(latch_wr), .latch_wdata(latch_wdata),
    .host_pointer_load(host_pointer_load), .host_ptr_value(host_ptr_value),
    .count_load(count_load), .count_value(count_value),
    .irq_events(irq_events), .scsi_irq_mask_a(scsi_irq_mask_a),
    .scsi_irq_clear_a(scsi_irq_clear_a), .pin_data(pin_data),
    .bus_irq_line_clear(bus_irq_line_clear), .pin_ack(pin_ack),
    .pin_rst(pin_rst), .dfifo_in_ready(1'b0), .dfifo_out_valid(dfo_v),
    .dfifo_out_data(dfo_d), .dfifo_in_valid(), .dfifo_in_data(),
    .dfifo_out_ready(), .req_o(req_o), .data_o(data_o), .data_oe(data_oe),
    .rst_o(rst_o), .pio_data_latch(pio_data_latch), .sync_active(sync_active),
    .pio_ready_flag(pio_ready_flag), .scsi_status_reg_a(scsi_status_reg_a),
    .bus_irq_line(bus_irq_line), .bus_count_done(bus_count_done),
    .bus_reset_seen(bus_reset_seen), .bus_byte_pointer(bus_byte_pointer),
    .remaining_byte_count(remaining_byte_count));

  stc_init_model u_init (
    .core_clk(core_clk), .req_o(req_o), .data_o(data_o), .data_oe(data_oe),
    .tx_byte(tx), .delay(dly), .pin_ack(pin_ack), .pin_data(pin_data),
    .rx_byte(rx));

  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse

  // Bounded wait for the ready flag
  task automatic wait_rdy();
    int n;
    n = 0;
    while (pio_ready_flag !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    if (pio_ready_flag !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t ready timeout", $time);
      give_verdict();
    end
  endtask : wait_rdy

  // One target Out byte through the latch
  task automatic xfer_out(input logic [7:0] b);
    tx = b;
    pulse(latch_rd);
    tick(2);
    wait_rdy();
    tick(3);
  endtask : xfer_out

  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    $display("[FAIL] %0t run timeout", $time);
    give_verdict();
  end

  // Main sequence
  initial begin
    {reset_n, bus_dma_enable, bus_engine_enable, dir_to_host, frst} = '0;
    {count_wrap_enable, clear_channel, bus_reset_out, sync_rate} = '0;
    {phase_mismatch_flag, latch_rd, latch_wr, count_load, dly} = '0;
    {host_pointer_load, bus_irq_line_clear, latch_wdata, tx} = '0;
    {irq_events, scsi_irq_mask_a, scsi_irq_clear_a, dfo_d, dfo_v} = '0;
    {host_ptr_value, count_value} = '0;
    {target_mode, auto_pio_enable} = 2'b11;
    phase = STC_PH_DATA;
    repeat (2) @(posedge core_clk);
    tick(1);
    reset_n = 1'b1;
    tick(4);
    host_ptr_value = 32'h0000_0100;
    count_value = 24'h000002;
    pulse(host_pointer_load);
    pulse(count_load);
    tick(1);
    chk(bus_byte_pointer === 32'h0000_0100, "pointer load");
    chk(remaining_byte_count === 24'h000002, "count load");
    // Out byte with a slow initiator
    dly = 4'h4;
    xfer_out(8'ha5);
    chk(pio_data_latch === 8'ha5, "latched byte");
    chk(remaining_byte_count === 24'h000001, "count step");
    chk(bus_byte_pointer === 32'h0000_0101, "pointer step");
    // Reading again raises REQ; last byte ends the count
    dly = 4'h0;
    tx = 8'h3c;
    pulse(latch_rd);
    tick(1);
    chk(req_o === 1'b1 && pio_ready_flag === 1'b0, "next req");
    wait_rdy();
    tick(3);
    chk(remaining_byte_count === 24'h000000, "count zero");
    chk(bus_count_done === 1'b1, "done flag");
    count_wrap_enable = 1'b1;
    xfer_out(8'hc3);
    chk(remaining_byte_count === 24'hffffff, "wrap");
    // Refused reads
    count_wrap_enable = 1'b0;
    count_value = 24'h000005;
    pulse(count_load);
    auto_pio_enable = 1'b0;
    pulse(latch_rd);
    tick(6);
    chk(req_o === 1'b0, "req with auto off");
    auto_pio_enable = 1'b1;
    phase_mismatch_flag = 1'b1;
    pulse(latch_rd);
    tick(6);
    chk(req_o === 1'b0, "req on mismatch");
    phase_mismatch_flag = 1'b0;
    // Target In byte
    dir_to_host = 1'b1;
    latch_wdata = 8'h96;
    pulse(latch_wr);
    tick(1);
    chk(req_o === 1'b1 && data_o === 8'h96, "in req");
    chk(data_oe === 1'b1 && pio_ready_flag === 1'b0, "in drive");
    wait_rdy();
    tick(1);
    chk(req_o === 1'b0 && rx === 8'h96, "in ack");
    tick(4);
    // DMA out: data FIFO bytes go out on the bus until the count ends
    {dir_to_host, auto_pio_enable} = 2'b00;
    count_value = 24'h000002;
    pulse(count_load);
    {dfo_d, dfo_v, bus_dma_enable, bus_engine_enable} = {8'h7e, 3'b111};
    tick(60);
    chk(rx === 8'h7e && data_o === 8'h7e, "dma byte");
    chk(remaining_byte_count === 24'h000000, "dma count");
    chk(bus_count_done === 1'b1, "dma done");
    // Clearing the channel drops bytes left in the bus FIFO
    {dfo_v, bus_dma_enable, bus_engine_enable} = 3'b000;
    pulse(clear_channel);
    count_value = 24'h000001;
    pulse(count_load);
    {bus_dma_enable, bus_engine_enable} = 2'b11;
    tick(8);
    chk(req_o === 1'b0, "flushed");
    {bus_dma_enable, bus_engine_enable} = 2'b00;
    // Rate setting only in the data phase
    sync_rate = 1'b1;
    phase = STC_PH_CMD;
    tick(4);
    chk(sync_active === 1'b0, "sync in command");
    phase = STC_PH_DATA;
    tick(4);
    chk(sync_active === 1'b1, "sync in data");
    // Interrupt masking, stacking and clearing
    scsi_irq_mask_a = 8'h14;
    irq_events = 8'h08;
    tick(4);
    chk(bus_irq_line === 1'b0 && scsi_status_reg_a[3], "unmasked");
    irq_events = 8'h0c;
    tick(4);
    chk(bus_irq_line === 1'b1, "masked event");
    irq_events = 8'h1c;
    tick(4);
    chk(scsi_status_reg_a[4:2] === 3'b111, "second event");
    // Clear write drops a bit whose condition still stands
    scsi_irq_clear_a = 8'h10;
    tick(2);
    chk(scsi_status_reg_a[4:2] === 3'b011, "clear write");
    irq_events = 8'h00;
    scsi_irq_clear_a = 8'hff;
    tick(4);
    chk(scsi_status_reg_a[4:2] === 3'b000, "sources clear");
    chk(bus_irq_line === 1'b1, "line held");
    scsi_irq_clear_a = 8'h00;
    pulse(bus_irq_line_clear);
    tick(2);
    chk(bus_irq_line === 1'b0, "line cleared");
    // Own and foreign bus reset
    bus_reset_out = 1'b1;
    tick(4);
    chk(rst_o === 1'b1, "reset driven");
    bus_reset_out = 1'b0;
    // The tail of our own reset must never read as foreign
    repeat (8) begin
      tick(1);
      chk(rst_o === 1'b0 && bus_reset_seen === 1'b0, "own reset");
    end
    frst = 1'b1;
    tick(6);
    chk(bus_reset_seen === 1'b1, "foreign reset");
    frst = 1'b0;
    give_verdict();
  end
endmodule : tb_top
